/* File: rtl/pbsc_pkg.sv */
package pbsc_pkg;
  localparam int ADDR_W    = 19;
  localparam int DATA_W    = 32;
  localparam int LANES     = 4;
  localparam int LANE_W    = 8;
  localparam int CELL_W    = LANE_W + 1;
  localparam int BEAT_W    = 2;
  localparam int BUF_DEPTH = 8;
  localparam int RAM_WORDS = 2 ** ADDR_W;
  localparam int BUF_W     = ADDR_W + LANES + LANES + DATA_W;

  // Floating strap pulls high
  localparam logic              ORDER_RESET = 1'h1;
  localparam logic [BEAT_W-1:0] BEAT_STEP   = 2'h1;
  localparam logic [LANES-1:0]  LANES_NONE  = 4'hF;

  typedef enum logic [1:0] {OP_IDLE, OP_RD, OP_WR} pbsc_op_t;
  typedef logic [ADDR_W-1:0] pbsc_addr_t;
endpackage

/* File: rtl/pbsc_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module pbsc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  // DEPTH must be a power of two: the pointers wrap by overflow
  localparam int               PTR_W    = $clog2(DEPTH);
  localparam logic [PTR_W-1:0] PTR_ONE  = PTR_W'(1);
  localparam logic [PTR_W:0]   CNT_ONE  = (PTR_W + 1)'(1);
  localparam logic [PTR_W:0]   CNT_FULL = (PTR_W + 1)'(DEPTH);

  typedef struct packed {
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [PTR_W:0]   count;
  } pbsc_fifo_st_t;

  pbsc_fifo_st_t    st;
  pbsc_fifo_st_t    next_st;
  logic [WIDTH-1:0] slots [DEPTH];
  logic             push;
  logic             pop;

  assign in_ready_o  = (st.count != CNT_FULL);
  assign out_valid_o = (st.count != '0);
  assign out_data_o  = slots[st.rd_ptr];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr_ptr = st.wr_ptr + PTR_ONE;
    end
    if (pop) begin
      next_st.rd_ptr = st.rd_ptr + PTR_ONE;
    end
    if (push && !pop) begin
      next_st.count = st.count + CNT_ONE;
    end else if (pop && !push) begin
      next_st.count = st.count - CNT_ONE;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Slot storage needs no reset; count guards every read
  always_ff @(posedge clk_i) begin
    if (push) begin
      slots[st.wr_ptr] <= in_data_i;
    end
  end
endmodule
`default_nettype wire

/* File: rtl/pbsc_sram_ctl.sv */
`timescale 1ns/100ps
`default_nettype none
module pbsc_sram_ctl (
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  input  wire logic                        clock_qualify_n_i,
  input  wire logic                        chip_select_1_n_i,
  input  wire logic                        chip_select_2_i,
  input  wire logic                        chip_select_3_n_i,
  input  wire logic                        step_or_fetch_addr_i,
  input  wire logic                        write_n_i,
  input  wire logic [pbsc_pkg::LANES-1:0]  byte_lane_select_n_i,
  input  wire logic [pbsc_pkg::ADDR_W-1:0] addr_i,
  input  wire logic                        out_drive_n_i,
  input  wire logic                        sleep_request_i,
  input  wire logic                        order_select_i,
  input  wire logic [pbsc_pkg::DATA_W-1:0] data_i,
  output logic      [pbsc_pkg::DATA_W-1:0] data_o,
  output logic                             data_oe_o,
  input  wire logic [pbsc_pkg::LANES-1:0]  parity_lines_i,
  output logic      [pbsc_pkg::LANES-1:0]  parity_lines_o,
  output logic                             parity_lines_oe_o,
  output logic                             wr_buf_ready_o,
  output logic                             sleep_active_o
);
  typedef struct packed {
    logic                        sleep_meta;
    logic                        sleep_sync;
    logic                        strap_done;
    logic                        interleave;
    logic                        burst_live;
    logic                        burst_write;
    pbsc_pkg::pbsc_addr_t        base_addr;
    logic [pbsc_pkg::BEAT_W-1:0] beat;
    pbsc_pkg::pbsc_op_t          s1_op;
    pbsc_pkg::pbsc_addr_t        s1_addr;
    logic [pbsc_pkg::LANES-1:0]  s1_mask_n;
    logic                        s2_wr;
    pbsc_pkg::pbsc_addr_t        s2_addr;
    logic [pbsc_pkg::LANES-1:0]  s2_mask_n;
    logic [pbsc_pkg::DATA_W-1:0] rd_data;
    logic [pbsc_pkg::LANES-1:0]  rd_par;
    logic                        drive;
    logic                        buf_ready;
  } pbsc_core_st_t;

  pbsc_core_st_t                st;
  pbsc_core_st_t                next_st;
  logic [pbsc_pkg::BEAT_W-1:0]  next_beat;
  logic [pbsc_pkg::DATA_W-1:0]  core_rd_data;
  logic [pbsc_pkg::LANES-1:0]   core_rd_par;
  logic                         edge_ok;
  logic                         buf_push;
  logic                         buf_in_ready;
  logic [pbsc_pkg::BUF_W-1:0]   buf_in;
  logic                         buf_valid;
  logic                         buf_pop_ok;
  logic [pbsc_pkg::BUF_W-1:0]   buf_out;
  logic                         drain;
  pbsc_pkg::pbsc_addr_t         drain_addr;
  logic [pbsc_pkg::LANES-1:0]   drain_mask_n;
  logic [pbsc_pkg::LANES-1:0]   drain_par;
  logic [pbsc_pkg::DATA_W-1:0]  drain_data;

  function automatic logic chips_on(
    input logic cs1_n,
    input logic cs2,
    input logic cs3_n
  );
    return !cs1_n && cs2 && !cs3_n;
  endfunction

  // Only the two low bits move; the upper address stays as loaded
  function automatic pbsc_pkg::pbsc_addr_t burst_addr(
    input pbsc_pkg::pbsc_addr_t        base,
    input logic [pbsc_pkg::BEAT_W-1:0] beat,
    input logic                        il
  );
    logic [pbsc_pkg::BEAT_W-1:0] low;
    low = il ? (base[pbsc_pkg::BEAT_W-1:0] ^ beat)
             : (base[pbsc_pkg::BEAT_W-1:0] + beat);
    return {base[pbsc_pkg::ADDR_W-1:pbsc_pkg::BEAT_W], low};
  endfunction

  assign edge_ok   = !clock_qualify_n_i && !st.sleep_sync;
  assign next_beat = st.beat + pbsc_pkg::BEAT_STEP;

  // Write data lands two qualified edges after its command
  assign buf_in   = {st.s2_addr, st.s2_mask_n, parity_lines_i, data_i};
  assign buf_push = edge_ok && st.s2_wr
                    && (st.s2_mask_n != pbsc_pkg::LANES_NONE);

  // Single-port core: reads win, queued writes wait for a free cycle
  assign buf_pop_ok = !st.sleep_sync
                      && !(edge_ok && st.s1_op == pbsc_pkg::OP_RD);

  pbsc_fifo #(
    .WIDTH (pbsc_pkg::BUF_W),
    .DEPTH (pbsc_pkg::BUF_DEPTH)
  ) u_wr_buf (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (buf_push),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (buf_in),
    .out_valid_o (buf_valid),
    .out_ready_i (buf_pop_ok),
    .out_data_o  (buf_out)
  );

  assign drain = buf_valid && buf_pop_ok;
  assign {drain_addr, drain_mask_n, drain_par, drain_data} = buf_out;

  // Each lane owns its byte plus parity bit, so a masked lane is never touched
  for (genvar i = 0; i < pbsc_pkg::LANES; i++) begin : g_lane
    logic [pbsc_pkg::CELL_W-1:0] cells [pbsc_pkg::RAM_WORDS];

    always_ff @(posedge clk_i) begin
      if (drain && !drain_mask_n[i]) begin
        cells[drain_addr] <= {drain_par[i],
          drain_data[i*pbsc_pkg::LANE_W +: pbsc_pkg::LANE_W]};
      end
    end

    assign core_rd_data[i*pbsc_pkg::LANE_W +: pbsc_pkg::LANE_W] =
      cells[st.s1_addr][pbsc_pkg::LANE_W-1:0];
    assign core_rd_par[i] = cells[st.s1_addr][pbsc_pkg::LANE_W];
  end

  always_comb begin
    next_st = st;
    next_st.sleep_meta = sleep_request_i;
    next_st.sleep_sync = st.sleep_meta;
    next_st.buf_ready  = buf_in_ready;

    // Strap is taken once after reset and then frozen
    if (!st.strap_done) begin
      next_st.interleave = order_select_i;
      next_st.strap_done = 1'h1;
    end

    if (st.sleep_sync) begin
      // Whatever was in flight is abandoned
      next_st.burst_live = 1'h0;
      next_st.s1_op      = pbsc_pkg::OP_IDLE;
      next_st.s2_wr      = 1'h0;
      next_st.drive      = 1'h0;
    end else if (!clock_qualify_n_i) begin
      // Output stage: only a read in stage one turns the pins on
      next_st.drive = (st.s1_op == pbsc_pkg::OP_RD)
                      && !out_drive_n_i;
      if (st.s1_op == pbsc_pkg::OP_RD) begin
        next_st.rd_data = core_rd_data;
        next_st.rd_par  = core_rd_par;
      end

      // Stage two waits one edge for the host to turn the bus around
      next_st.s2_wr     = (st.s1_op == pbsc_pkg::OP_WR);
      next_st.s2_addr   = st.s1_addr;
      next_st.s2_mask_n = st.s1_mask_n;

      // Command stage accepts a new command every qualified edge
      if (!step_or_fetch_addr_i) begin
        if (chips_on(chip_select_1_n_i, chip_select_2_i,
                     chip_select_3_n_i)) begin
          next_st.burst_live  = 1'h1;
          next_st.burst_write = !write_n_i;
          next_st.base_addr   = addr_i;
          next_st.beat        = '0;
          next_st.s1_addr     = addr_i;
          next_st.s1_mask_n   = byte_lane_select_n_i;
          next_st.s1_op       = write_n_i ? pbsc_pkg::OP_RD
                                          : pbsc_pkg::OP_WR;
        end else begin
          next_st.burst_live = 1'h0;
          next_st.s1_op      = pbsc_pkg::OP_IDLE;
        end
      end else begin
        // Advance ignores selects and strobe; a dead burst stays deselected
        next_st.beat      = next_beat;
        next_st.s1_addr   = burst_addr(st.base_addr, next_beat,
                                       st.interleave);
        next_st.s1_mask_n = byte_lane_select_n_i;
        if (!st.burst_live) begin
          next_st.s1_op = pbsc_pkg::OP_IDLE;
        end else if (st.burst_write) begin
          next_st.s1_op = pbsc_pkg::OP_WR;
        end else begin
          next_st.s1_op = pbsc_pkg::OP_RD;
        end
      end
    end
  end

  // Power-up leaves the device deselected with pins off
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st            <= '0;
      st.interleave <= pbsc_pkg::ORDER_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign data_o            = st.rd_data;
  assign parity_lines_o    = st.rd_par;
  assign data_oe_o         = st.drive;
  assign parity_lines_oe_o = st.drive;
  assign wr_buf_ready_o    = st.buf_ready;
  assign sleep_active_o    = st.sleep_sync;
endmodule
`default_nettype wire

/* File: verification/pbsc_sram_ctl_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module pbsc_sram_ctl_chk (
  input wire logic                        clk_i,
  input wire logic                        rst_i,
  input wire logic                        clock_qualify_n_i,
  input wire logic                        chip_select_1_n_i,
  input wire logic                        chip_select_2_i,
  input wire logic                        chip_select_3_n_i,
  input wire logic                        step_or_fetch_addr_i,
  input wire logic                        write_n_i,
  input wire logic                        out_drive_n_i,
  input wire logic                        sleep_request_i,
  input wire logic [pbsc_pkg::DATA_W-1:0] data_o,
  input wire logic                        data_oe_o,
  input wire logic                        parity_lines_oe_o,
  input wire logic                        sleep_active_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire q = !clock_qualify_n_i;
  wire sel = !chip_select_1_n_i && chip_select_2_i && !chip_select_3_n_i;
  wire ld = q && !step_or_fetch_addr_i && !sleep_active_o;
  wire rd = ld && sel && write_n_i;
  wire wr = ld && sel && !write_n_i;
  property p_rd_oe; rd ##1 (q && !out_drive_n_i) |=> data_oe_o; endproperty
  a_rd_oe: assert property (p_rd_oe) else $error("read not driven");
  property p_wr_off; wr ##1 q |=> !data_oe_o; endproperty
  a_wr_off: assert property (p_wr_off) else $error("driven in write");
  property p_desel; ld && !sel ##1 q |=> !data_oe_o; endproperty
  a_desel: assert property (p_desel) else $error("driven after deselect");
  // Sleep is excluded: it may clear the pipeline on its own
  property p_hold;
    !q && !sleep_request_i && !sleep_active_o |=> $stable(data_o) && $stable(data_oe_o);
  endproperty
  a_hold: assert property (p_hold) else $error("stall edge changed output");
  property p_odn; q && out_drive_n_i |=> !data_oe_o; endproperty
  a_odn: assert property (p_odn) else $error("driven while disabled");
  property p_oe_eq; data_oe_o == parity_lines_oe_o; endproperty
  a_oe_eq: assert property (p_oe_eq) else $error("enables differ");
  property p_slp_in; sleep_request_i [*4] |-> sleep_active_o; endproperty
  a_slp_in: assert property (p_slp_in) else $error("sleep late");
  property p_slp_out; !sleep_request_i [*4] |-> !sleep_active_o; endproperty
  a_slp_out: assert property (p_slp_out) else $error("wake late");
  c_rd: cover property (rd);
  c_wr: cover property (wr);
  c_slp: cover property ($rose(sleep_active_o));
endmodule
bind pbsc_sram_ctl pbsc_sram_ctl_chk chk (.clk_i, .rst_i, .clock_qualify_n_i,
  .chip_select_1_n_i, .chip_select_2_i, .chip_select_3_n_i, .step_or_fetch_addr_i,
  .write_n_i, .out_drive_n_i, .sleep_request_i, .data_o, .data_oe_o,
  .parity_lines_oe_o, .sleep_active_o);
`default_nettype wire

/* File: verification/pbsc_host_bus.sv */
`timescale 1ns/100ps
`default_nettype none
module pbsc_host_bus (
  input  wire logic        clk_i,
  input  wire logic [35:0] dev_d_i,
  input  wire logic        dev_oe_i,
  input  wire logic [35:0] hst_d_i,
  input  wire logic        hst_en_i,
  output logic      [35:0] bus_o
);
  logic [35:0] last;
  always_ff @(posedge clk_i) last <= bus_o;
  // Host only drives once the device lets go; a floating bus keeps changing
  assign bus_o = dev_oe_i ? dev_d_i : hst_en_i ? hst_d_i : ~last;
endmodule
`default_nettype wire

/* File: verification/pbsc_sram_ctl_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module pbsc_sram_ctl_tb;
  logic                        clk, rst, cqn, cs1n, cs2, cs3n, stp, wrn, odn, slp;
  logic                        strap, hen, ql, doe, poe, rdy, slpa;
  logic [3:0]                  ben, pq;
  pbsc_pkg::pbsc_addr_t        adr;
  logic [pbsc_pkg::DATA_W-1:0] dq;
  logic [35:0]                 hd, bus, d0, d1, d2;
  int                          k0, k1, k2, num_errors, checks_done, cycles;
  pbsc_sram_ctl uut (.clk_i(clk), .rst_i(rst), .clock_qualify_n_i(cqn),
    .chip_select_1_n_i(cs1n), .chip_select_2_i(cs2), .chip_select_3_n_i(cs3n),
    .step_or_fetch_addr_i(stp), .write_n_i(wrn), .byte_lane_select_n_i(ben),
    .addr_i(adr), .out_drive_n_i(odn), .sleep_request_i(slp), .order_select_i(strap),
    .data_i(bus[31:0]), .data_o(dq), .data_oe_o(doe), .parity_lines_i(bus[35:32]),
    .parity_lines_o(pq), .parity_lines_oe_o(poe), .wr_buf_ready_o(rdy),
    .sleep_active_o(slpa));
  pbsc_host_bus host (.clk_i(clk), .dev_d_i({pq, dq}), .dev_oe_i(doe), .hst_d_i(hd),
    .hst_en_i(hen), .bus_o(bus));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    if (num_errors == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(string n, logic [35:0] got, logic [35:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", n, exp, got);
    end
  endtask
  // Kind 1 read, 2 write; data goes out or is compared two taken edges later
  task automatic cyc(bit q, bit s, bit st, bit wn, logic [3:0] b, pbsc_pkg::pbsc_addr_t a,
                     int k, logic [35:0] d);
    if (!ql) begin
      k2 = k1;
      d2 = d1;
      k1 = k0;
      d1 = d0;
      hen = (k2 == 2);
      hd = d2;
      if (k2 == 1) chk("oe", 36'(doe), 36'(!odn));
      if (k2 == 1 && !odn) chk("rdata", {pq, dq}, d2);
    end
    k0 = k;
    d0 = d;
    ql = q;
    cqn = q;
    {cs1n, cs2, cs3n} = {!s, s, !s};
    {stp, wrn, ben, adr} = {st, wn, b, a};
    @(negedge clk);
  endtask
  task automatic idle(int n);
    repeat (n) cyc(0, 0, 0, 1, 4'hF, 19'h0, 0, 36'h0);
  endtask
  task automatic do_reset(bit m);
    strap = m;
    rst = 1'b1;
    {k0, k1, k2} = {32'h0, 32'h0, 32'h0};
    {hen, ql} = 2'h0;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    idle(2);
    chk("oe_rst", 36'(doe), 36'h0);
    chk("buf_rdy", 36'(rdy), 36'h1);
  endtask
  function automatic logic [35:0] exp_at(logic [1:0] j);
    for (int k = 0; k < 4; k++) begin
      if (strap ? (2'h1 ^ 2'(k)) == j : (2'h1 + 2'(k)) == j) return 36'h9_0000_0000 + 36'(k);
    end
    return 36'h0;
  endfunction
  task automatic t_burst();
    cyc(0, 1, 0, 0, 4'h0, 19'h01231, 2, 36'h9_0000_0000);
    for (int k = 1; k < 4; k++) begin
      cyc(0, 0, 1, 1, 4'h0, 19'h0, 2, 36'h9_0000_0000 + 36'(k));
    end
    idle(8);
    cyc(0, 1, 0, 1, 4'hF, 19'h01230, 1, exp_at(2'h0));
    for (int j = 1; j < 5; j++) begin
      if (j == 2) cyc(1, 1, 0, 0, 4'h0, 19'h7, 0, 36'h0);
      cyc(0, 0, 1, 0, 4'hF, 19'h0, 1, exp_at(2'(j)));
    end
    idle(3);
  endtask
  task automatic t_lanes();
    cyc(0, 1, 0, 0, 4'h0, 19'h00200, 2, 36'h0_1122_3344);
    cyc(0, 1, 0, 0, 4'h5, 19'h00200, 2, 36'hF_AABB_CCDD);
    idle(8);
    cyc(0, 1, 0, 1, 4'hF, 19'h00200, 1, 36'hA_AA22_CC44);
    cyc(0, 1, 0, 1, 4'hF, 19'h00200, 1, 36'hA_AA22_CC44);
    idle(2);
    odn = 1'b1;
    cyc(0, 1, 0, 1, 4'hF, 19'h00200, 1, 36'h0);
    idle(2);
    odn = 1'b0;
  endtask
  task automatic t_sleep();
    slp = 1'b1;
    idle(4);
    chk("sleep_in", 36'(slpa), 36'h1);
    slp = 1'b0;
    idle(4);
    chk("sleep_out", 36'(slpa), 36'h0);
    cyc(0, 1, 0, 1, 4'hF, 19'h00200, 1, 36'hA_AA22_CC44);
    idle(2);
  endtask
  initial begin
    {cqn, cs1n, cs2, cs3n, stp, wrn, odn, slp, hen, ql} = 10'h150;
    {ben, adr, hd} = {4'hF, 19'h0, 36'h0};
    do_reset(1'b0);
    t_burst();
    t_lanes();
    t_sleep();
    do_reset(1'b1);
    t_burst();
    end_sim();
  end
endmodule
`default_nettype wire
